//--- twbm_master.v
// Purpose: register-driven two-wire bus master for one or two byte transfers
// Assumes: pins synchronous to clk; 400 kHz enable supplied by the time base
// Notes:   open-drain pins, output enable low while driving low
// Notes on behaviour
// - master only, 400 kHz bus clock
// - one or two bytes, single direction
// - seven registers carry all control and data
// - completion raises external interrupt six
// - interrupt withdrawn when next transfer starts
// - bus timing from time-base 400 kHz enable
// - address bits 7..1, bit 0 direction
// - first write byte sent first
// - control bit 1 starts the transfer
// - two-byte read captures second byte
// - first received byte in first read register
// - second write byte sent only if length
// - start bit reads busy, self-clears
// - missing acknowledge sets error, start clears
// - control bit 0 selects two bytes
// - done flag bit 2, enable bit 3
`include "twbm_defines.vh"
module twbm_master (
   input  wire        clk,       // system clock, 25 MHz
   input  wire        sys_rst,   // synchronous reset, active high
   input  wire        tick400,   // 400 kHz enable from time base
   input  wire [15:0] sfrAddr,   // special-function register address
   input  wire        sfrWr,     // write strobe
   input  wire        sfrRd,     // read strobe
   input  wire [7:0]  sfrWdata,  // write data
   output reg  [7:0]  sfrRdata,  // read data, valid one cycle after sfrRd
   input  wire        sdaIn,     // data line level
   output reg         sdaOut,    // data line drive value, always low
   output reg         sdaOeN,    // data line enable, low drives
   output reg         sclOut,    // clock line drive value, always low
   output reg         sclOeN,    // clock line enable, low drives
   output reg         irqSix     // external interrupt six request
);
   // one-hot states
   localparam [5:0] ST_IDLE  = 6'h01;
   localparam [5:0] ST_WAIT  = 6'h02;
   localparam [5:0] ST_START = 6'h04;
   localparam [5:0] ST_BITS  = 6'h08;
   localparam [5:0] ST_ACK   = 6'h10;
   localparam [5:0] ST_STOP  = 6'h20;

   // register select codes
   localparam [2:0] SEL_NONE = 3'h0;
   localparam [2:0] SEL_SAD  = 3'h1;
   localparam [2:0] SEL_WB1  = 3'h2;
   localparam [2:0] SEL_WB2  = 3'h3;
   localparam [2:0] SEL_RB1  = 3'h4;
   localparam [2:0] SEL_RB2  = 3'h5;
   localparam [2:0] SEL_CTL  = 3'h6;
   localparam [2:0] SEL_IRQ  = 3'h7;

   reg  [7:0] slaveAddressDirection_q;
   reg  [7:0] firstWriteByte_q;
   reg  [7:0] secondWriteByte_q;
   reg  [7:0] firstReadByte_q;
   reg  [7:0] secondReadByte_q;
   reg        twoByteSelect_q;
   reg        transferGoBusy_q;
   reg        noAckError_q;
   reg        transferDoneFlag_q;
   reg        transferDoneIrqEnable_q;
   reg  [5:0] state_q;
   reg  [2:0] bitCnt_q;
   reg        inAddr_q;
   reg        byteNo_q;
   reg        lenRun_q;
   reg        dirRun_q;
   reg        shLoad;
   reg  [7:0] shVal;
   reg        finish;
   wire [7:0] shWord;
   wire       slotP;
   wire       highP;
   wire       sampP;
   wire [2:0] wrSel;
   wire [2:0] rdSel;
   wire       goReq;
   wire [7:0] rxByte;

   // address decode used for both reads and writes
   function [2:0] sfrSel;
      input [15:0] a;
      begin
         case (a)
            `TWBM_ADDR_SAD:  sfrSel = SEL_SAD;
            `TWBM_ADDR_WB1:  sfrSel = SEL_WB1;
            `TWBM_ADDR_WB2:  sfrSel = SEL_WB2;
            `TWBM_ADDR_RB1:  sfrSel = SEL_RB1;
            `TWBM_ADDR_RB2:  sfrSel = SEL_RB2;
            `TWBM_ADDR_CTL:  sfrSel = SEL_CTL;
            `TWBM_ADDR_IRQ6: sfrSel = SEL_IRQ;
            default:         sfrSel = SEL_NONE;
         endcase
      end
   endfunction

   assign wrSel  = sfrWr ? sfrSel(sfrAddr) : SEL_NONE;
   assign rdSel  = sfrRd ? sfrSel(sfrAddr) : SEL_NONE;
   // a start request while busy is ignored
   assign goReq  = (wrSel == SEL_CTL) && sfrWdata[`TWBM_CTL_GO] && !transferGoBusy_q;
   assign rxByte = {shWord[6:0], sdaIn};

   // slot timing from the time-base enable
   twbm_phase u_phase (
      .clk     (clk),
      .sys_rst (sys_rst),
      .tick    (tick400),
      .slotP   (slotP),
      .highP   (highP),
      .sampP   (sampP)
   );

   // byte shifter, shifts in the line at each sample point of a data bit
   twbm_shifter #(
      .WIDTH (8)
   ) u_shift (
      .clk     (clk),
      .sys_rst (sys_rst),
      .load    (shLoad),
      .loadVal (shVal),
      .shift   (sampP && (state_q == ST_BITS)),
      .bitIn   (sdaIn),
      .word    (shWord)
   );

   // software-written registers
   always @(posedge clk) begin
      if (sys_rst) begin
         slaveAddressDirection_q <= `TWBM_RST_BYTE;
         firstWriteByte_q        <= `TWBM_RST_BYTE;
         secondWriteByte_q       <= `TWBM_RST_BYTE;
         twoByteSelect_q         <= 1'b0;
         transferDoneIrqEnable_q <= 1'b0;
      end else begin
         case (wrSel)
            SEL_SAD: slaveAddressDirection_q <= sfrWdata;
            SEL_WB1: firstWriteByte_q <= sfrWdata;
            SEL_WB2: secondWriteByte_q <= sfrWdata;
            SEL_CTL: twoByteSelect_q <= sfrWdata[`TWBM_CTL_LEN];
            SEL_IRQ: transferDoneIrqEnable_q <= sfrWdata[`TWBM_IRQ6_EN];
            default: twoByteSelect_q <= twoByteSelect_q;
         endcase
      end
   end

   // read mux, registered; unmapped addresses read zero
   always @(posedge clk) begin
      if (sys_rst)
         sfrRdata <= `TWBM_RST_BYTE;
      else begin
         case (rdSel)
            SEL_SAD: sfrRdata <= slaveAddressDirection_q;
            SEL_WB1: sfrRdata <= firstWriteByte_q;
            SEL_WB2: sfrRdata <= secondWriteByte_q;
            SEL_RB1: sfrRdata <= firstReadByte_q;
            SEL_RB2: sfrRdata <= secondReadByte_q;
            SEL_CTL: sfrRdata <= {5'h00, noAckError_q, transferGoBusy_q, twoByteSelect_q};
            SEL_IRQ: sfrRdata <= {4'h0, transferDoneIrqEnable_q, transferDoneFlag_q, 2'h0};
            default: sfrRdata <= `TWBM_RST_BYTE;
         endcase
      end
   end

   // shifter loads: address byte, then write bytes or released line for reads
   always @* begin
      shLoad = 1'b0;
      shVal  = `TWBM_RELEASE_BYTE;
      finish = 1'b0;
      if (state_q == ST_WAIT && slotP) begin
         shLoad = 1'b1;
         shVal  = slaveAddressDirection_q;
      end else if (state_q == ST_ACK && sampP) begin
         if (inAddr_q && !sdaIn) begin
            shLoad = 1'b1;
            shVal  = dirRun_q ? `TWBM_RELEASE_BYTE : firstWriteByte_q;
         end else if (!inAddr_q && !byteNo_q && lenRun_q && (dirRun_q || !sdaIn)) begin
            shLoad = 1'b1;
            shVal  = dirRun_q ? `TWBM_RELEASE_BYTE : secondWriteByte_q;
         end
      end
      if (state_q == ST_STOP && sampP)
         finish = 1'b1;
   end

   // transfer sequencer, one bit per slot
   always @(posedge clk) begin
      if (sys_rst) begin
         state_q  <= ST_IDLE;
         bitCnt_q <= 3'h0;
         inAddr_q <= 1'b0;
         byteNo_q <= 1'b0;
         lenRun_q <= 1'b0;
         dirRun_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (goReq) begin
                  state_q  <= ST_WAIT;
                  lenRun_q <= sfrWdata[`TWBM_CTL_LEN];
                  dirRun_q <= slaveAddressDirection_q[`TWBM_SAD_DIR];
               end
            end
            ST_WAIT: begin
               if (slotP) begin
                  state_q  <= ST_START;
                  inAddr_q <= 1'b1;
                  byteNo_q <= 1'b0;
               end
            end
            ST_START: begin
               if (sampP) begin
                  state_q  <= ST_BITS;
                  bitCnt_q <= 3'h0;
               end
            end
            ST_BITS: begin
               if (sampP) begin
                  bitCnt_q <= bitCnt_q + 3'h1;
                  if (bitCnt_q == `TWBM_LAST_BIT)
                     state_q <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (sampP) begin
                  bitCnt_q <= 3'h0;
                  if (shLoad) begin
                     state_q  <= ST_BITS;
                     byteNo_q <= !inAddr_q;
                     inAddr_q <= 1'b0;
                  end else
                     state_q <= ST_STOP;
               end
            end
            ST_STOP: begin
               if (sampP)
                  state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // received bytes land in the read registers
   always @(posedge clk) begin
      if (sys_rst) begin
         firstReadByte_q  <= `TWBM_RST_BYTE;
         secondReadByte_q <= `TWBM_RST_BYTE;
      end else if (state_q == ST_BITS && sampP && bitCnt_q == `TWBM_LAST_BIT
                   && dirRun_q && !inAddr_q) begin
         if (byteNo_q)
            secondReadByte_q <= rxByte;
         else
            firstReadByte_q <= rxByte;
      end
   end

   // status: busy, acknowledge error, done flag and interrupt
   always @(posedge clk) begin
      if (sys_rst) begin
         transferGoBusy_q   <= 1'b0;
         noAckError_q       <= 1'b0;
         transferDoneFlag_q <= 1'b0;
         irqSix             <= 1'b0;
      end else begin
         if (goReq) begin
            transferGoBusy_q   <= 1'b1;
            noAckError_q       <= 1'b0;
            transferDoneFlag_q <= 1'b0;
         end else if (finish) begin
            transferGoBusy_q   <= 1'b0;
            transferDoneFlag_q <= 1'b1;
         end
         if (state_q == ST_ACK && sampP && (inAddr_q || !dirRun_q) && sdaIn)
            noAckError_q <= 1'b1;
         irqSix <= transferDoneFlag_q && transferDoneIrqEnable_q;
      end
   end

   // open-drain pin drive; master owns the clock line
   always @(posedge clk) begin
      if (sys_rst) begin
         sclOut <= 1'b0;
         sdaOut <= 1'b0;
         sclOeN <= 1'b1;
         sdaOeN <= 1'b1;
      end else begin
         sclOut <= 1'b0;
         sdaOut <= 1'b0;
         case (state_q)
            ST_START: begin
               if (sampP)
                  sdaOeN <= 1'b0;
            end
            ST_BITS: begin
               if (slotP) begin
                  sclOeN <= 1'b0;
                  sdaOeN <= shWord[7];
               end else if (highP)
                  sclOeN <= 1'b1;
            end
            ST_ACK: begin
               if (slotP) begin
                  sclOeN <= 1'b0;
                  // last read byte gets a not-acknowledge
                  sdaOeN <= !(dirRun_q && !inAddr_q && !byteNo_q && lenRun_q);
               end else if (highP)
                  sclOeN <= 1'b1;
            end
            ST_STOP: begin
               if (slotP) begin
                  sclOeN <= 1'b0;
                  sdaOeN <= 1'b0;
               end else if (highP)
                  sclOeN <= 1'b1;
               else if (sampP)
                  sdaOeN <= 1'b1;
            end
            default: begin
               sclOeN <= 1'b1;
               sdaOeN <= 1'b1;
            end
         endcase
      end
   end
endmodule

//--- twbm_defines.vh
// Purpose: constants for the two-wire byte master
// Assumes: 25 MHz system clock, 400 kHz bus enable from the time base
// Notes:   offsets are the special-function register addresses
`ifndef TWBM_DEFINES_VH
`define TWBM_DEFINES_VH

// special-function register addresses
`define TWBM_ADDR_SAD      16'hFF80
`define TWBM_ADDR_WB1      16'hFF81
`define TWBM_ADDR_WB2      16'hFF82
`define TWBM_ADDR_RB1      16'hFF83
`define TWBM_ADDR_RB2      16'hFF84
`define TWBM_ADDR_CTL      16'hFF85
`define TWBM_ADDR_IRQ6     16'hFF95

// reset value of every register
`define TWBM_RST_BYTE      8'h00

// field positions
`define TWBM_SAD_DIR       0
`define TWBM_CTL_LEN       0
`define TWBM_CTL_GO        1
`define TWBM_CTL_NAKERR    2
`define TWBM_IRQ6_FLAG     2
`define TWBM_IRQ6_EN       3

// bus timing: one bit slot per 400 kHz enable
`define TWBM_CLK_NS        40
`define TWBM_SLOT_NS       2500
`define TWBM_HIGH_AT_NS    (`TWBM_SLOT_NS / 2)
`define TWBM_SAMPLE_AT_NS  ((`TWBM_SLOT_NS * 3) / 4)
`define TWBM_HIGH_CYC      (`TWBM_HIGH_AT_NS / `TWBM_CLK_NS)
`define TWBM_SAMPLE_CYC    (`TWBM_SAMPLE_AT_NS / `TWBM_CLK_NS)

// bits per byte and idle shifter fill
`define TWBM_LAST_BIT      3'h7
`define TWBM_RELEASE_BYTE  8'hFF
`endif

//--- twbm_phase.v
// Purpose: splits each 400 kHz bus slot into low, high and sample points
// Assumes: tick arrives as a one-cycle enable from the chip time base
// Notes:   the slot length comes from the tick, not from a free divider
`include "twbm_defines.vh"
module twbm_phase #(
   parameter HIGH_CYC   = `TWBM_HIGH_CYC,
   parameter SAMPLE_CYC = `TWBM_SAMPLE_CYC
) (
   input  wire       clk,      // system clock
   input  wire       sys_rst,  // synchronous reset
   input  wire       tick,     // 400 kHz slot enable
   output wire       slotP,    // slot start, scl goes low
   output reg        highP,    // scl release point
   output reg        sampP     // sda sample point
);
   reg  [5:0] cnt_q;
   reg        run_q;

   assign slotP = tick;

   // count system cycles from each slot start
   always @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= 6'h00;
         run_q <= 1'b0;
         highP <= 1'b0;
         sampP <= 1'b0;
      end else begin
         highP <= run_q && (cnt_q == HIGH_CYC[5:0] - 6'h01);
         sampP <= run_q && (cnt_q == SAMPLE_CYC[5:0] - 6'h01);
         if (tick) begin
            cnt_q <= 6'h01;
            run_q <= 1'b1;
         end else if (run_q) begin
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == SAMPLE_CYC[5:0])
               run_q <= 1'b0;
         end
      end
   end
endmodule

//--- twbm_shifter.v
// Purpose: byte shift register shared by send and receive
// Assumes: msb first on the bus
// Notes:   shifting in the sampled line keeps a sent byte and a read byte alike
module twbm_shifter #(
   parameter WIDTH = 8
) (
   input  wire             clk,      // system clock
   input  wire             sys_rst,  // synchronous reset
   input  wire             load,     // load a new byte
   input  wire [WIDTH-1:0] loadVal,  // byte to load
   input  wire             shift,    // shift one bit in
   input  wire             bitIn,    // sampled data line
   output reg  [WIDTH-1:0] word      // current contents
);
   // load has priority over shift
   always @(posedge clk) begin
      if (sys_rst)
         word <= {WIDTH{1'b0}};
      else if (load)
         word <= loadVal;
      else if (shift)
         word <= {word[WIDTH-2:0], bitIn};
   end
endmodule

//--- twbm_master_properties.sv
// Purpose: port checks of the byte master
// Assumes: registered outputs, 25 MHz clk
// Notes:   bound to twbm_master
`include "twbm_defines.vh"
module twbm_master_properties (
   input wire        clk,       // clock
   input wire        sys_rst,   // reset
   input wire        tick400,   // slot enable
   input wire [15:0] sfrAddr,   // address
   input wire        sfrWr,     // write
   input wire        sfrRd,     // read
   input wire [7:0]  sfrWdata,  // write data
   input wire [7:0]  sfrRdata,  // read data
   input wire        sdaIn,     // data level
   input wire        sdaOut,    // data drive
   input wire        sdaOeN,    // data enable
   input wire        sclOut,    // clock drive
   input wire        sclOeN,    // clock enable
   input wire        irqSix     // done request
);
   reg [7:0] sadQ_q;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // shadow of the address register
   always @(posedge clk) begin
      if (sys_rst) sadQ_q <= 8'h00;
      else if (sfrWr && sfrAddr == `TWBM_ADDR_SAD) sadQ_q <= sfrWdata;
   end
   property p_rst; disable iff (1'b0)
      sys_rst |=> sfrRdata == 8'h00 && sclOeN && sdaOeN && !irqSix; endproperty
   a_rst: assert property (p_rst) else $error("not idle after reset");
   property p_sclLow; $fell(sclOeN) |-> ##31 $rose(sclOeN); endproperty
   a_sclLow: assert property (p_sclLow) else $error("clock low time wrong");
   property p_sclTick; $fell(sclOeN) |-> $past(tick400); endproperty
   a_sclTick: assert property (p_sclTick) else $error("clock fell off slot");
   property p_sdaSteady; !sclOeN && $past(!sclOeN) |-> $stable(sdaOeN); endproperty
   a_sdaSteady: assert property (p_sdaSteady) else $error("data moved in low");
   property p_mask; sfrWr && sfrAddr == `TWBM_ADDR_IRQ6 && !sfrWdata[3] |-> ##2 !irqSix;
   endproperty
   a_mask: assert property (p_mask) else $error("masked request high");
   property p_drop; sfrWr && sfrAddr == `TWBM_ADDR_CTL && sfrWdata[1] && irqSix
      |-> ##2 !irqSix; endproperty
   a_drop: assert property (p_drop) else $error("request kept after start");
   property p_unmap; sfrRd && sfrAddr > `TWBM_ADDR_CTL && sfrAddr < `TWBM_ADDR_IRQ6
      |=> sfrRdata == 8'h00; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_sad; sfrRd && sfrAddr == `TWBM_ADDR_SAD |=> sfrRdata == sadQ_q; endproperty
   a_sad: assert property (p_sad) else $error("address register mismatch");
   property p_idle; irqSix |-> sclOeN && sdaOeN; endproperty
   a_idle: assert property (p_idle) else $error("done while bus driven");
   c_done: cover property ($rose(irqSix));
   c_drop: cover property (sfrWr && sfrAddr == `TWBM_ADDR_CTL && sfrWdata[1] && irqSix);
   c_rd2: cover property (sfrRd && sfrAddr == `TWBM_ADDR_RB2);
endmodule
bind twbm_master twbm_master_properties chk (.clk(clk), .sys_rst(sys_rst),
   .tick400(tick400), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
   .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOeN(sdaOeN), .sclOut(sclOut), .sclOeN(sclOeN), .irqSix(irqSix));

//--- twbm_slave_model.sv
// Purpose: behavioural two-wire slave
// Assumes: pulled-up lines
// Notes:   nakAll withholds every acknowledge
module twbm_slave_model (
   input  wire        scl,      // clock line
   input  wire        sda,      // data line
   input  wire        nakAll,   // refuse acks
   input  wire [15:0] txWord,   // read bytes
   output reg         pullN,    // 0 pulls low
   output reg  [7:0]  gotAddr,  // address byte
   output reg  [15:0] gotWord,  // written bytes
   output reg  [1:0]  gotCnt    // written count
);
   timeunit 1ns;
   timeprecision 1ns;
   reg [7:0] sh;
   reg       rd;
   reg       quiet;
   integer   cnt;
   integer   nb;
   initial begin
      pullN = 1'b1;
      quiet = 1'b1;
      gotCnt = 2'd0;
   end
   // start and stop framing
   // judged a moment later: data moving as the clock falls is no frame edge
   always @(negedge sda) begin
      #1;
      if (scl) begin
         cnt = -1;
         nb = 0;
         quiet = 1'b0;
         gotCnt = 2'd0;
      end
   end
   always @(posedge sda) begin
      #1;
      if (scl) quiet = 1'b1;
   end
   // take a bit, a byte or the master's ack
   always @(posedge scl) if (!quiet) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      else if (nb == 0) begin
         gotAddr = sh;
         rd = sh[0];
      end else if (!rd) begin
         gotWord = {gotWord[7:0], sh};
         gotCnt = gotCnt + 2'd1;
      end else if (sda) quiet = 1'b1;
   end
   // ack or read data after the clock falls
   always @(negedge scl) if (!quiet) begin
      if (cnt == 8) begin
         cnt = 0;
         nb = nb + 1;
      end else cnt = cnt + 1;
      if (cnt == 8 && (nb == 0 || !rd)) pullN = nakAll;
      else if (cnt < 8 && rd && nb > 0 && nb < 3) pullN = txWord[23 - 8 * nb - cnt];
      else pullN = 1'b1;
   end
endmodule

//--- twbm_master_bench.sv
// Purpose: register-level bench of the byte master
// Assumes: 25 MHz clock, slave model on the lines
// Notes:   slot enable alternates 62 and 63 cycles
`include "twbm_defines.vh"
`define CHK(nm, ex, got) begin \
   check_count = check_count + 1; \
   if ((got) !== (ex)) begin \
      err_total = err_total + 1; \
      $display("ERROR %s expected %h seen %h", nm, ex, got); \
   end \
end
module twbm_master_bench;
   timeunit 1ns;
   timeprecision 1ns;
   reg         clk = 1'b0;
   reg         sys_rst = 1'b1;
   reg         tick400 = 1'b0;
   reg [15:0]  sfrAddr = 16'h0000;
   reg         sfrWr = 1'b0;
   reg         sfrRd = 1'b0;
   reg [7:0]   sfrWdata = 8'h00;
   reg         nakAll = 1'b0;
   reg [15:0]  txWord = 16'h0000;
   reg [6:0]   tickCnt = 7'h00;
   integer     err_total = 0;
   integer     check_count = 0;
   integer     i;
   wire [7:0]  sfrRdata, gotAddr;
   wire [15:0] gotWord;
   wire [1:0]  gotCnt;
   wire        sdaOut, sdaOeN, sclOut, sclOeN, irqSix, pullN;
   // open-drain lines with pull-ups
   wire        sclW = sclOeN | sclOut;
   wire        sdaW = (sdaOeN | sdaOut) & pullN;
   always #20 clk = ~clk;
   // slot enable from the time base
   always @(posedge clk) begin
      tickCnt <= #1 (tickCnt == 7'h7c) ? 7'h00 : tickCnt + 7'h01;
      tick400 <= #1 (tickCnt == 7'h7c) || (tickCnt == 7'h3d);
   end
   twbm_master DUT (.clk(clk), .sys_rst(sys_rst), .tick400(tick400), .sfrAddr(sfrAddr),
      .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata),
      .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclOut(sclOut),
      .sclOeN(sclOeN), .irqSix(irqSix));
   twbm_slave_model slave (.scl(sclW), .sda(sdaW), .nakAll(nakAll), .txWord(txWord),
      .pullN(pullN), .gotAddr(gotAddr), .gotWord(gotWord), .gotCnt(gotCnt));
   // one register write
   task wr(input [15:0] a, input [7:0] d);
      begin
         @(posedge clk) #1;
         sfrAddr = a;
         sfrWdata = d;
         sfrWr = 1'b1;
         @(posedge clk) #1;
         sfrWr = 1'b0;
      end
   endtask
   // one register read and compare
   task chk(input [15:0] a, input [7:0] ex);
      begin
         @(posedge clk) #1;
         sfrAddr = a;
         sfrRd = 1'b1;
         @(posedge clk) #1;
         sfrRd = 1'b0;
         // read data stands for one cycle only, look at it now
         `CHK($sformatf("reg %h", a), ex, sfrRdata)
      end
   endtask
   // bounded wait for the done request
   task waitDone;
      begin
         i = 0;
         repeat (3) @(posedge clk);
         while (irqSix !== 1'b1 && i < 4000) begin
            @(posedge clk);
            i = i + 1;
         end
         `CHK("done request", 1'b1, irqSix)
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", check_count, err_total);
         if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
         else $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      #2000000;
      err_total = err_total + 1;
      report_and_stop;
   end
   // main sequence
   initial begin
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'b0;
      for (i = 0; i < 6; i = i + 1) chk(`TWBM_ADDR_SAD + i[15:0], 8'h00);
      chk(`TWBM_ADDR_IRQ6, 8'h00);
      wr(16'hff86, 8'h5a);
      chk(16'hff86, 8'h00);
      wr(`TWBM_ADDR_RB1, 8'h5a);
      chk(`TWBM_ADDR_RB1, 8'h00);
      wr(`TWBM_ADDR_IRQ6, 8'h08);
      // one-byte write, second byte ignored
      wr(`TWBM_ADDR_SAD, 8'h50);
      wr(`TWBM_ADDR_WB1, 8'h3c);
      wr(`TWBM_ADDR_WB2, 8'h99);
      chk(`TWBM_ADDR_SAD, 8'h50);
      wr(`TWBM_ADDR_CTL, 8'h02);
      chk(`TWBM_ADDR_CTL, 8'h02);
      waitDone;
      chk(`TWBM_ADDR_CTL, 8'h00);
      chk(`TWBM_ADDR_IRQ6, 8'h0c);
      `CHK("address byte", 8'h50, gotAddr)
      `CHK("byte count", 2'd1, gotCnt)
      `CHK("first byte", 8'h3c, gotWord[7:0])
      // two-byte write withdraws the old flag
      wr(`TWBM_ADDR_CTL, 8'h03);
      chk(`TWBM_ADDR_IRQ6, 8'h08);
      waitDone;
      `CHK("two bytes", 16'h3c99, gotWord)
      `CHK("byte count", 2'd2, gotCnt)
      // two-byte then one-byte read
      txWord = 16'ha55a;
      wr(`TWBM_ADDR_SAD, 8'h51);
      wr(`TWBM_ADDR_CTL, 8'h03);
      waitDone;
      chk(`TWBM_ADDR_RB1, 8'ha5);
      chk(`TWBM_ADDR_RB2, 8'h5a);
      txWord = 16'h81ff;
      wr(`TWBM_ADDR_CTL, 8'h02);
      waitDone;
      chk(`TWBM_ADDR_RB1, 8'h81);
      chk(`TWBM_ADDR_RB2, 8'h5a);
      // refused ack, cleared by next start
      nakAll = 1'b1;
      wr(`TWBM_ADDR_SAD, 8'h50);
      wr(`TWBM_ADDR_CTL, 8'h02);
      waitDone;
      chk(`TWBM_ADDR_CTL, 8'h04);
      nakAll = 1'b0;
      wr(`TWBM_ADDR_CTL, 8'h02);
      chk(`TWBM_ADDR_CTL, 8'h02);
      waitDone;
      // masking keeps the flag only
      wr(`TWBM_ADDR_IRQ6, 8'h00);
      chk(`TWBM_ADDR_IRQ6, 8'h04);
      `CHK("masked request", 1'b0, irqSix)
      report_and_stop;
   end
endmodule
